/* busctl_params.svh */
// Timing counts and field positions for the bus control and error signalling ends.
// Assumes inclusion by bare name from the package and both end modules.
`ifndef BUSCTL_PARAMS_SVH
`define BUSCTL_PARAMS_SVH
// ----------------------------------------------------------------------
// Command register field positions
// ----------------------------------------------------------------------
`define CMD_WIDTH        11
`define CMD_PERR_ENA_BIT 6
`define CMD_SERR_ENA_BIT 8
`define CMD_INT_DIS_BIT  10
`define CMD_RESET        11'h000
// ----------------------------------------------------------------------
// Timing and widths
// ----------------------------------------------------------------------
`define PERR_DELAY_CYCLES 2
`define AD_WIDTH          64
`define CBE_WIDTH         8
`define BUF_DEPTH         2
`endif

/* busctl_pkg.sv */
// Types shared by both ends of the bus control link.
// Assumes busctl_params.svh is on the include path.
`include "busctl_params.svh"
package busctl_pkg;
	// Target state machine, Gray along idle, claim, data, turnaround.
	typedef enum logic [1:0] {
		T_IDLE  = 2'b00,
		T_CLAIM = 2'b01,
		T_DATA  = 2'b11,
		T_TURN  = 2'b10
	} tgt_state_t;
	// Master state machine, Gray along idle, address, data, turnaround.
	typedef enum logic [1:0] {
		M_IDLE = 2'b00,
		M_ADDR = 2'b01,
		M_DATA = 2'b11,
		M_TURN = 2'b10
	} mst_state_t;
	// Word carried by a data phase.
	typedef struct packed {
		logic [`AD_WIDTH-1:0]  ad;
		logic [`CBE_WIDTH-1:0] cbe;
	} word_t;
endpackage

/* busctl_if.sv */
// Interface joining the device end to the bus party end.
// Assumes the testbench resolves open-drain and shared wires from the enables.
`timescale 1ns/1ps
`include "busctl_params.svh"
interface busctl_if;
	import busctl_pkg::*;
	logic                  frame_b;      // Frame, active low, from master.
	logic                  req64_b;      // 64-bit request, active low.
	logic                  irdy_b;       // Initiator ready, active low.
	logic                  devsel_b;     // Device select, active low.
	logic                  ack64_b;      // 64-bit acknowledge, active low.
	logic                  trdy_b;       // Target ready, active low.
	logic                  stop_b;       // Stop, active low.
	logic [`AD_WIDTH-1:0]  ad;           // Address/data from master.
	logic [`CBE_WIDTH-1:0] cbe_b;        // Command/byte enables from master.
	logic                  par;          // Lower parity from master.
	logic                  par64;        // Upper parity from master.
	logic                  perr_b_out;   // Parity error output, active low.
	logic                  perr_oe;      // Parity error drive enable.
	logic                  serr_b_out;   // System error output, always low.
	logic                  serr_oe;      // System error drive enable.
	logic                  inta_b_out;   // Interrupt output, always low.
	logic                  inta_oe;      // Interrupt drive enable.
	logic                  ctl_oe;       // Target control drive enable.
	modport device (
		input  frame_b, req64_b, irdy_b, ad, cbe_b, par, par64,
		output devsel_b, ack64_b, trdy_b, stop_b, ctl_oe,
		output perr_b_out, perr_oe, serr_b_out, serr_oe, inta_b_out, inta_oe
	);
	modport party (
		output frame_b, req64_b, irdy_b, ad, cbe_b, par, par64,
		input  devsel_b, ack64_b, trdy_b, stop_b, ctl_oe,
		input  perr_b_out, perr_oe, serr_b_out, serr_oe, inta_b_out, inta_oe
	);
endinterface

/* busctl_party.sv */
// Bus party end: a master that issues single-phase writes to the device.
// Assumes the device end answers over busctl_if on the same clock.
`timescale 1ns/1ps
`include "busctl_params.svh"
module busctl_party
	import busctl_pkg::*;
(
	input  wire logic  CORE_CLK,   // Bus clock.
	input  wire logic  RST_B,      // Asynchronous reset, active low.
	busctl_if.party    BUS,        // Link to the device end.
	input  wire logic  START,      // Pulse that starts a transaction.
	input  wire logic  WIDE,       // Request a 64-bit transaction.
	input  wire logic [`AD_WIDTH-1:0] ADDR, // Address to drive.
	input  wire logic [`AD_WIDTH-1:0] DATA, // Data to drive.
	input  wire logic  BAD_PAR,    // Corrupt the data parity.
	output logic       BUSY,       // Transaction in progress.
	output logic       DONE,       // Pulse when the data phase completed.
	output logic       STOPPED     // Pulse when the target asked to stop.
);
	mst_state_t           state;       // Master state.
	mst_state_t           next_state;  // Next master state.
	logic [`AD_WIDTH-1:0] drv_ad;      // Address/data being driven.
	logic [`AD_WIDTH-1:0] next_drv_ad; // Next driven address/data.
	logic                 wide;        // Transaction is 64-bit.
	logic                 next_wide;   // Next width flag.
	logic                 bad;         // Parity corruption latched.
	logic                 next_bad;    // Next corruption flag.
	logic                 busy, next_busy, done, next_done, stp, next_stp;
	logic                 par_q, par64_q, next_par, next_par64;

	// Computes the next master state; frame and 64-bit request share timing.
	always_comb begin
		next_state  = state;
		next_drv_ad = drv_ad;
		next_wide   = wide;
		next_bad    = bad;
		next_done   = 1'b0;
		next_stp    = 1'b0;
		unique case (state)
			M_IDLE: begin
				if (START) begin
					next_state  = M_ADDR;
					next_drv_ad = ADDR;
					next_wide   = WIDE;
					next_bad    = BAD_PAR;
				end
			end
			M_ADDR: begin
				next_state  = M_DATA;
				next_drv_ad = DATA;
			end
			M_DATA: begin
				// The phase completes when both ready lines are low.
				if (!BUS.irdy_b && !BUS.trdy_b) begin
					next_state = M_TURN;
					next_done  = 1'b1;
				end else if (!BUS.stop_b) begin
					next_state = M_TURN;
					next_stp   = 1'b1;
				end
			end
			M_TURN: next_state = M_IDLE;
		endcase
		next_busy = (next_state != M_IDLE);
		// Parity follows the driven phase by one clock.
		next_par   = ^{drv_ad[31:0], BUS.cbe_b[3:0]} ^ (bad && state == M_DATA);
		next_par64 = ^{drv_ad[63:32], BUS.cbe_b[7:4]};
	end

	// Registers the master state.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state   <= M_IDLE;
			drv_ad  <= '0;
			wide    <= 1'b0;
			bad     <= 1'b0;
			busy    <= 1'b0;
			done    <= 1'b0;
			stp     <= 1'b0;
			par_q   <= 1'b0;
			par64_q <= 1'b0;
		end else begin
			state   <= next_state;
			drv_ad  <= next_drv_ad;
			wide    <= next_wide;
			bad     <= next_bad;
			busy    <= next_busy;
			done    <= next_done;
			stp     <= next_stp;
			par_q   <= next_par;
			par64_q <= next_par64;
		end
	end

	// Frame marks the address cycle of a single-phase write; irdy means write data is valid.
	assign BUS.frame_b = !(state == M_ADDR);
	assign BUS.req64_b = !(state == M_ADDR && wide);
	assign BUS.irdy_b  = !(state == M_DATA);
	assign BUS.ad      = drv_ad;
	assign BUS.cbe_b   = (state == M_ADDR) ? 8'h07 : 8'h00;
	assign BUS.par     = par_q;
	assign BUS.par64   = par64_q;
	assign BUSY        = busy;
	assign DONE        = done;
	assign STOPPED     = stp;
endmodule // busctl_party

/* busctl_device.sv */
// Device end: target control, parity error, system error and interrupt signalling.
// Assumes one bus clock; the testbench resolves open-drain wires from the enables.
`timescale 1ns/1ps
`include "busctl_params.svh"
// Overview of operation
// - 64-bit request has frame timing.
// - 64-bit acknowledge has device-select timing.
// - Device select only after own decode.
// - Target ready when data phase can finish.
// - Initiator ready when master can finish.
// - Stop with ready and select encodes termination.
// - Parity error two clocks after bad phase.
// - Parity error needs mismatch and enable bit.
// - Upper parity checked only in 64-bit.
// - System error on address parity, enabled.
// - Interrupt while request and not disabled.
// - Bidirectional controls split into in/out.
// - Phase completes when both readies low.
// - Parity is even over covered bits.
// - Reset releases all bus outputs.
module busctl_device
	import busctl_pkg::*;
#(
	parameter logic [`AD_WIDTH-1:0] BASE = 64'h0000_0000_0001_0000, // Claimed base.
	parameter logic [`AD_WIDTH-1:0] MASK = 64'hffff_ffff_ffff_f000, // Decode mask.
	parameter int                   DEPTH = `BUF_DEPTH              // Buffer depth.
)(
	input  wire logic                  CORE_CLK,  // Bus clock.
	input  wire logic                  RST_B,     // Asynchronous reset, active low.
	busctl_if.device                   BUS,       // Link to the bus party.
	input  wire logic [`CMD_WIDTH-1:0] CMD,       // Command register bits.
	input  wire logic                  LIRQ_B,    // Local interrupt request, low.
	input  wire logic                  RETRY,     // Ask the master to stop.
	output logic [`AD_WIDTH-1:0]       WORD,      // Received data word.
	output logic                       WORD_VALID,// Word available.
	input  wire logic                  WORD_READY,// Local side takes the word.
	output logic                       PERR_SEEN, // Data parity error flag pulse.
	output logic                       SERR_SEEN  // Address parity error flag pulse.
);
	// ----------------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------------
	tgt_state_t           state, next_state;      // Target state.
	logic                 wide, next_wide;        // Transaction is 64-bit.
	logic                 addr_ph, next_addr_ph;  // Address phase last cycle.
	logic                 data_ph, next_data_ph;  // Data phase last cycle.
	logic [`AD_WIDTH-1:0] ad_q, next_ad_q;        // Sampled address/data.
	logic [`CBE_WIDTH-1:0] cbe_q, next_cbe_q;     // Sampled command/enables.
	logic                 has_word, next_has_word; // Buffer holds a word, registered.
	logic                 perr_o, next_perr_o;    // Parity error drive.
	logic                 serr_o, next_serr_o;    // System error drive.
	logic                 int_o, next_int_o;      // Interrupt drive.
	logic                 pe_seen, se_seen;       // Flag pulses.
	logic                 ctl_o, next_ctl_o;      // Target controls driven.
	logic                 devsel_o, trdy_o, stop_o, ack64_o;
	logic                 next_devsel, next_trdy, next_stop, next_ack64;
	logic [`AD_WIDTH-1:0] buf_mem [DEPTH];        // Two-entry word buffer.
	logic [1:0]           count, next_count;      // Words held.
	logic                 wp, rp, next_wp, next_rp;
	logic                 lo_bad, hi_bad, claim, take, give, buf_full;

	// Even parity check over one lane of sampled bits plus its parity.
	function automatic logic odd_ones(input logic [31:0] a, input logic [3:0] c,
		input logic p);
		odd_ones = ^{a, c, p};
	endfunction

	// ----------------------------------------------------------------------
	// Target handshake and error detection
	// ----------------------------------------------------------------------
	// Parity of a phase arrives one clock later, so check it against the sampled phase.
	always_comb begin
		lo_bad   = odd_ones(ad_q[31:0], cbe_q[3:0], BUS.par);
		hi_bad   = wide && odd_ones(ad_q[63:32], cbe_q[7:4], BUS.par64);
		claim    = ((BUS.ad & MASK) == BASE);
		buf_full = (count == 2'(DEPTH));
		take     = 1'b0;
		next_state   = state;
		next_wide    = wide;
		next_addr_ph = 1'b0;
		next_data_ph = 1'b0;
		next_ad_q    = BUS.ad;
		next_cbe_q   = BUS.cbe_b;
		next_devsel  = 1'b0;
		next_trdy    = 1'b0;
		next_stop    = 1'b0;
		next_ack64   = 1'b0;
		next_ctl_o   = 1'b0;
		unique case (state)
			T_IDLE: begin
				if (!BUS.frame_b) begin
					next_addr_ph = 1'b1;
					next_wide    = !BUS.req64_b;
					if (claim) begin
						next_state = T_CLAIM;
					end
				end
			end
			T_CLAIM: begin
				// Decoded as ours: select and acknowledge rise together.
				next_state  = T_DATA;
				next_devsel = 1'b1;
				next_ack64  = wide;
				next_ctl_o  = 1'b1;
				next_trdy   = !buf_full && !RETRY;
				next_stop   = RETRY;
			end
			T_DATA: begin
				next_ctl_o  = 1'b1;
				next_devsel = 1'b1;
				next_ack64  = wide;
				if (!BUS.irdy_b && trdy_o) begin
					take         = 1'b1;
					next_data_ph = 1'b1;
					next_state   = T_TURN;
					next_devsel  = 1'b0;
					next_ack64   = 1'b0;
				end else if (stop_o) begin
					next_state  = T_TURN;
					next_devsel = 1'b0;
					next_ack64  = 1'b0;
				end else begin
					next_trdy = !buf_full && !RETRY;
					next_stop = RETRY;
				end
			end
			T_TURN: next_state = T_IDLE;
			default: next_state = T_IDLE;
		endcase
		// Parity is checked on the clock after the phase and the error is driven
		// straight from that check, so it lands two clocks after the data phase.
		next_perr_o = data_ph && (lo_bad || hi_bad) && CMD[`CMD_PERR_ENA_BIT];
		next_serr_o = addr_ph && (lo_bad || hi_bad) && CMD[`CMD_SERR_ENA_BIT];
		next_int_o  = !LIRQ_B && !CMD[`CMD_INT_DIS_BIT];
	end

	// Registers the target and error state; reset releases every driver.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			state    <= T_IDLE;
			wide     <= 1'b0;
			addr_ph  <= 1'b0;
			data_ph  <= 1'b0;
			ad_q     <= '0;
			cbe_q    <= '0;
			devsel_o <= 1'b0;
			trdy_o   <= 1'b0;
			stop_o   <= 1'b0;
			ack64_o  <= 1'b0;
			ctl_o    <= 1'b0;
			perr_o   <= 1'b0;
			serr_o   <= 1'b0;
			int_o    <= 1'b0;
			pe_seen  <= 1'b0;
			se_seen  <= 1'b0;
		end else begin
			state    <= next_state;
			wide     <= next_wide;
			addr_ph  <= next_addr_ph;
			data_ph  <= next_data_ph;
			ad_q     <= next_ad_q;
			cbe_q    <= next_cbe_q;
			devsel_o <= next_devsel;
			trdy_o   <= next_trdy;
			stop_o   <= next_stop;
			ack64_o  <= next_ack64;
			ctl_o    <= next_ctl_o;
			perr_o   <= next_perr_o;
			serr_o   <= next_serr_o;
			int_o    <= next_int_o;
			pe_seen  <= next_perr_o;
			se_seen  <= next_serr_o;
		end
	end

	// ----------------------------------------------------------------------
	// Two-entry word buffer toward the local side
	// ----------------------------------------------------------------------
	// Target ready is withheld while full, so a local stall loses no word.
	always_comb begin
		give       = WORD_VALID && WORD_READY;
		next_wp    = wp ^ take;
		next_rp    = rp ^ give;
		next_count = count + {1'b0, take} - {1'b0, give};
		// Valid is registered so the local side sees a clean flop output.
		next_has_word = (next_count != 2'h0);
	end

	// Registers the buffer pointers, the word count and the valid flag.
	always_ff @(posedge CORE_CLK or negedge RST_B) begin
		if (!RST_B) begin
			wp    <= 1'b0;
			rp    <= 1'b0;
			count <= 2'h0;
			has_word <= 1'b0;
		end else begin
			wp    <= next_wp;
			rp    <= next_rp;
			count <= next_count;
			has_word <= next_has_word;
		end
	end

	// Storage carries no reset; it is only read while count is nonzero.
	always_ff @(posedge CORE_CLK) begin
		if (take) begin
			buf_mem[wp] <= BUS.ad;
		end
	end

	// Split outputs: value halves and enables, never a tri-state port.
	assign BUS.devsel_b   = !devsel_o;
	assign BUS.trdy_b     = !trdy_o;
	assign BUS.stop_b     = !stop_o;
	assign BUS.ack64_b    = !ack64_o;
	assign BUS.ctl_oe     = ctl_o;
	assign BUS.perr_b_out = !perr_o;
	assign BUS.perr_oe    = perr_o;
	assign BUS.serr_b_out = 1'b0;
	assign BUS.serr_oe    = serr_o;
	assign BUS.inta_b_out = 1'b0;
	assign BUS.inta_oe    = int_o;
	assign WORD           = buf_mem[rp];
	assign WORD_VALID     = has_word;
	assign PERR_SEEN      = pe_seen;
	assign SERR_SEEN      = se_seen;
endmodule // busctl_device

/* busctl_monitor.sv */
// Checker of the link between the party end and the device end.
// Assumes the bench top wires it to the interface and the device command bits.
`timescale 1ns/1ps
`include "busctl_params.svh"
module busctl_monitor #(
	parameter logic [`AD_WIDTH-1:0] BASE = 64'h0000_0000_0001_0000, // Claimed base.
	parameter logic [`AD_WIDTH-1:0] MASK = 64'hffff_ffff_ffff_f000  // Decode mask.
)(
	input wire logic                  CORE_CLK,
	input wire logic                  RST_B,
	input wire logic                  frame_b,
	input wire logic                  req64_b,
	input wire logic                  irdy_b,
	input wire logic                  devsel_b,
	input wire logic                  ack64_b,
	input wire logic                  trdy_b,
	input wire logic                  stop_b,
	input wire logic [`AD_WIDTH-1:0]  ad,
	input wire logic [`CBE_WIDTH-1:0] cbe_b,
	input wire logic                  par,
	input wire logic                  perr_b_out,
	input wire logic                  perr_oe,
	input wire logic                  serr_b_out,
	input wire logic                  serr_oe,
	input wire logic                  inta_b_out,
	input wire logic                  inta_oe,
	input wire logic                  ctl_oe,
	input wire logic [`CMD_WIDTH-1:0] CMD,
	input wire logic                  LIRQ_B
);
	// ----------------------------------------------------------------------
	// Helper terms
	// ----------------------------------------------------------------------
	logic lo_par;   // Xor of the lower half; even parity means par equals it.
	logic hit;      // Address cycle aimed at this device.
	logic dphase;   // Both readies low, so a data phase completes.
	logic irq_want; // Interrupt should be driven.
	logic perr_ena; // Parity error response enable.
	logic serr_ena; // System error enable.
	assign lo_par = ^{ad[31:0], cbe_b[3:0]};
	assign hit = !frame_b && ((ad & MASK) == BASE);
	assign dphase = !irdy_b && !trdy_b;
	assign irq_want = !LIRQ_B && !CMD[`CMD_INT_DIS_BIT];
	assign perr_ena = CMD[`CMD_PERR_ENA_BIT];
	assign serr_ena = CMD[`CMD_SERR_ENA_BIT];
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	AST_REQ64_FRAME: assert property ($fell(req64_b) |-> $fell(frame_b))
		else $error("wide request not aligned with frame");
	AST_ACK64_DEVSEL: assert property (!ack64_b |-> !devsel_b)
		else $error("wide acknowledge without device select");
	AST_CLAIM_DECODE: assert property ($fell(devsel_b) |-> $past(hit, 2))
		else $error("device select without own address");
	AST_CTL_IN_CLAIM: assert property (!trdy_b || !stop_b |-> !devsel_b && ctl_oe)
		else $error("ready or stop outside a claim");
	AST_DEVSEL_HOLDS: assert property (!devsel_b && stop_b && !dphase |=> !devsel_b)
		else $error("device select dropped before completion");
	AST_PERR_TIMING: assert property (dphase && perr_ena ##1 par != $past(lo_par)
		|=> perr_oe && !perr_b_out)
		else $error("parity error not driven two clocks after bad phase");
	AST_PERR_CAUSE: assert property ($rose(perr_oe) |-> $past(perr_ena) && $past(dphase, 2))
		else $error("parity error without enable or data phase");
	AST_SERR_PULSE: assert property (serr_oe |-> serr_ena ##1 !serr_oe)
		else $error("system error not a single enabled pulse");
	AST_INTA_FOLLOWS: assert property ($past(RST_B) |-> inta_oe == $past(irq_want))
		else $error("interrupt drive does not follow request");
	AST_OD_LOW_ONLY: assert property ((serr_oe |-> !serr_b_out) and (inta_oe |-> !inta_b_out))
		else $error("open drain line driven high");
	AST_RESET_QUIET: assert property (disable iff (1'b0)
		!RST_B |-> !(ctl_oe || perr_oe || serr_oe || inta_oe))
		else $error("output driven during reset");
	cover property (dphase);
	cover property (!stop_b);
	cover property (perr_oe);
	cover property (inta_oe);
endmodule // busctl_monitor

/* bus_handshake_error_signaling_tb_top.sv */
// Bench: party and device joined, and a raw driver on a second link.
// Assumes the design files and the monitor are compiled first.
`timescale 1ns/1ps
module bus_handshake_error_signaling_tb_top;
	import busctl_pkg::*;
	typedef struct {logic w; logic [63:0] d; logic b; logic [10:0] c; int e;} row_t;
	localparam logic [63:0] BASE = 64'h0000_0000_0001_0000; // Claimed base.
	logic        CORE_CLK = 1'b0;
	logic        RST_B = 1'b1;
	logic [10:0] cmd = 11'h000;
	logic        lirq_b = 1'b1;
	logic        retry = 1'b0;
	logic        word_ready = 1'b0;
	logic        start = 1'b0;
	logic        wide = 1'b0;
	logic [63:0] addr = BASE;
	logic [63:0] data = 64'h0;
	logic        bad_par = 1'b0;
	logic        busy, done, stopped, word_valid, perr_seen, serr_seen;
	logic        serr_seen2;
	logic [63:0] word;
	int          n_fail = 0, compares = 0, cyc = 0;
	int          perr_n = 0, serr_n = 0, dev_n = 0, ack_n = 0, stop_n = 0;
	int          flag_n = 0, sflag_n = 0, smain_n = 0; // Flag output pulse counts.
	// Ordinary writes: width, data, corrupt parity, command, parity error expected.
	row_t rows [5] = '{'{1'b0, 64'h0000_0000_a5a5_0001, 1'b0, 11'h040, 0},
		'{1'b0, 64'h0000_0000_5a5a_0002, 1'b1, 11'h040, 1},
		'{1'b0, 64'h0000_0000_0f0f_0003, 1'b1, 11'h000, 0},
		'{1'b1, 64'h1234_5678_9abc_def0, 1'b1, 11'h140, 1},
		'{1'b1, 64'hffff_0000_ffff_0000, 1'b0, 11'h540, 0}};
	busctl_if bus();
	busctl_if bus2();
	always #5 CORE_CLK = ~CORE_CLK;
	busctl_party i_busctl_party (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .BUS(bus), .START(start),
		.WIDE(wide), .ADDR(addr), .DATA(data), .BAD_PAR(bad_par), .BUSY(busy), .DONE(done),
		.STOPPED(stopped));
	busctl_device i_busctl_device (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .BUS(bus), .CMD(cmd),
		.LIRQ_B(lirq_b), .RETRY(retry), .WORD(word), .WORD_VALID(word_valid),
		.WORD_READY(word_ready), .PERR_SEEN(perr_seen), .SERR_SEEN(serr_seen));
	busctl_device i_busctl_device_2 (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .BUS(bus2), .CMD(cmd),
		.LIRQ_B(1'b1), .RETRY(1'b0), .WORD(), .WORD_VALID(), .WORD_READY(1'b1),
		.PERR_SEEN(), .SERR_SEEN(serr_seen2));
	busctl_monitor i_busctl_monitor (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .frame_b(bus.frame_b),
		.req64_b(bus.req64_b), .irdy_b(bus.irdy_b), .devsel_b(bus.devsel_b),
		.ack64_b(bus.ack64_b), .trdy_b(bus.trdy_b), .stop_b(bus.stop_b), .ad(bus.ad),
		.cbe_b(bus.cbe_b), .par(bus.par), .perr_b_out(bus.perr_b_out), .perr_oe(bus.perr_oe),
		.serr_b_out(bus.serr_b_out), .serr_oe(bus.serr_oe), .inta_b_out(bus.inta_b_out),
		.inta_oe(bus.inta_oe), .ctl_oe(bus.ctl_oe), .CMD(cmd), .LIRQ_B(lirq_b));
	// Counts wire events each cycle and cuts a hang short.
	always @(posedge CORE_CLK) begin
		cyc++;
		if (bus.perr_oe && !bus.perr_b_out) perr_n++;
		if (!bus.ack64_b) ack_n++;
		if (!bus.stop_b) stop_n++;
		if (bus2.serr_oe && !bus2.serr_b_out) serr_n++;
		if (!bus2.devsel_b) dev_n++;
		if (perr_seen) flag_n++;
		if (serr_seen2) sflag_n++;
		if (serr_seen) smain_n++;
		if (cyc == 3000) begin
			n_fail++;
			summarize();
		end
	end
	task automatic summarize();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Starts one write from the party end.
	task automatic send(input logic w, input logic [63:0] d, input logic b, input logic [10:0] c);
		@(posedge CORE_CLK);
		start <= 1'b1;
		wide <= w;
		data <= d;
		bad_par <= b;
		cmd <= c;
		@(posedge CORE_CLK);
		start <= 1'b0;
	endtask
	// Waits for completion (1) or stop (0x2), then lets the parity report land.
	task automatic wait_end(output int got);
		int k;
		got = 0;
		k = 0;
		while (got == 0 && k < 20) begin
			@(negedge CORE_CLK);
			k++;
			if (done === 1'b1) got = 1;
			else if (stopped === 1'b1) got = 2;
		end
		repeat (3) @(negedge CORE_CLK);
	endtask
	// Checks the buffer head and takes it.
	task automatic pop(input logic [63:0] d);
		chk("valid", 1'b1, word_valid);
		chk("word", d, word);
		@(posedge CORE_CLK);
		word_ready <= 1'b1;
		@(posedge CORE_CLK);
		word_ready <= 1'b0;
		@(negedge CORE_CLK);
	endtask
	// Drives one raw write on the second link; address parity may be broken.
	task automatic raw(input logic [63:0] a, input logic b, input logic [10:0] c, output int s,
		output int v);
		int s0, v0;
		s0 = serr_n;
		v0 = dev_n;
		@(posedge CORE_CLK);
		cmd <= c;
		bus2.frame_b <= 1'b0;
		bus2.ad <= a;
		bus2.cbe_b <= 8'h07;
		@(posedge CORE_CLK);
		bus2.frame_b <= 1'b1;
		bus2.irdy_b <= 1'b0;
		bus2.ad <= 64'h0;
		bus2.cbe_b <= 8'h00;
		bus2.par <= ^{a[31:0], 4'h7} ^ b;
		@(posedge CORE_CLK);
		bus2.par <= 1'b0;
		@(posedge CORE_CLK);
		bus2.irdy_b <= 1'b1;
		repeat (5) @(posedge CORE_CLK);
		s = serr_n - s0;
		v = dev_n - v0;
	endtask
	initial begin : main
		int got, p0, a0, s, v, f0;
		// A non-blocking write at time zero gives every flop with an asynchronous reset a falling reset edge.
		RST_B <= 1'b0;
		bus2.frame_b = 1'b1;
		bus2.req64_b = 1'b1;
		bus2.irdy_b = 1'b1;
		bus2.ad = 64'h0;
		bus2.cbe_b = 8'h00;
		bus2.par = 1'b0;
		bus2.par64 = 1'b0;
		repeat (2) @(posedge CORE_CLK);
		RST_B <= 1'b1;
		foreach (rows[i]) begin
			p0 = perr_n;
			a0 = ack_n;
			f0 = flag_n;
			send(rows[i].w, rows[i].d, rows[i].b, rows[i].c);
			wait_end(got);
			chk("done", 1, got);
			chk("perr", rows[i].e, perr_n != p0);
			chk("ack64", rows[i].w, ack_n != a0);
			chk("perr seen", rows[i].e, flag_n != f0);
			pop(rows[i].d);
		end
		// Fill the two-entry buffer; the third write must stall until a pop.
		for (int i = 0; i < 3; i++) begin
			send(1'b0, rows[i].d, 1'b0, 11'h000);
			wait_end(got);
			chk("fill", i < 2, got);
			chk("busy", i == 2, busy);
		end
		pop(rows[0].d);
		wait_end(got);
		chk("resume", 1, got);
		pop(rows[1].d);
		pop(rows[2].d);
		chk("empty", 1'b0, word_valid);
		// Target asks to stop: no word must enter the buffer.
		@(posedge CORE_CLK);
		retry <= 1'b1;
		p0 = stop_n;
		send(1'b0, rows[3].d, 1'b0, 11'h000);
		wait_end(got);
		chk("stopped", 2, got);
		chk("stop seen", 1'b1, stop_n != p0);
		chk("no word", 1'b0, word_valid);
		@(posedge CORE_CLK);
		retry <= 1'b0;
		// Interrupt over all request and disable combinations.
		for (int i = 0; i < 4; i++) begin
			@(posedge CORE_CLK);
			lirq_b <= i[0];
			cmd <= {i[1], 10'h000};
			repeat (3) @(negedge CORE_CLK);
			chk("inta", i != 0, !bus.inta_oe);
		end
		// Address parity, claim and decode on the second link.
		raw(BASE, 1'b1, 11'h100, s, v);
		chk("serr", 1, s);
		chk("claim", 1'b1, v != 0);
		raw(BASE, 1'b1, 11'h000, s, v);
		chk("serr off", 0, s);
		raw(64'h0000_0000_0002_0000, 1'b0, 11'h100, s, v);
		chk("no claim", 0, v);
		chk("serr flag", 1, sflag_n);
		chk("serr main", 0, smain_n);
		// Reset in mid-run while an interrupt is driven.
		@(posedge CORE_CLK);
		lirq_b <= 1'b0;
		cmd <= 11'h000;
		repeat (3) @(posedge CORE_CLK);
		RST_B <= 1'b0;
		@(negedge CORE_CLK);
		chk("quiet", 4'h0, {bus.ctl_oe, bus.perr_oe, bus.serr_oe, bus.inta_oe});
		chk("devsel", 1'b1, bus.devsel_b);
		repeat (2) @(posedge CORE_CLK);
		RST_B <= 1'b1;
		lirq_b <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		summarize();
	end
endmodule // bus_handshake_error_signaling_tb_top
